/* common/lprs_pkg.sv */
// Functional notes
// [RQ1] sleep: main oscillator stopped, internal clocks withheld, state kept, pins held static
// [RQ2] sleep: internal RC oscillator output gated, oscillator stays powered
// [RQ3] real-time-clock oscillator keeps running through sleep for wake-up interrupts
// [RQ4] sleep entry switches the PLL off and disconnects it by hardware
// [RQ5] sleep entry clears processor and USB clock dividers to zero
// [RQ6] sleep ends only on reset or on a clockless wake interrupt
// [RQ7] flash stays powered in sleep; no flash start-up wait after sleep
// [RQ8] sleep wake from internal RC clock resumes after 4 RC cycles
// [RQ9] sleep wake from main oscillator holds execution for 4096 oscillator cycles
// [RQ10] software reprograms PLL and dividers after every wake
// [RQ11] power-down does all of sleep, plus RC oscillator and flash off
// [RQ12] power-down wake: 60 us RC start-up, then 4 RC cycles before SRAM code
// [RQ13] power-down wake: flash blocked until 100 us counted in 4 MHz RC cycles; the code counts FLASH_CLKS = 25000 aclk cycles instead
// [RQ14] four reset sources: pin, watchdog, power-on, brownout
// [RQ15] internal reset held until pin released, oscillator up, count done, flash ready
// [RQ16] after reset the core fetches at address 0, boot vector, registers at reset values
// [RQ17] first brownout stage raises an interrupt request, also readable in status
// [RQ18] second brownout stage asserts chip reset to protect flash
// [RQ19] protect level one: debug off, limited programming, sector 0 locked
// [RQ20] protect level two: debug off, only full erase and reprogram
// [RQ21] protect level three: debug and programming off, loader entry pin ignored
// [RQ22] enabled external interrupts wake the device from power-down
// [RQ23] vectors at address zero map to boot ROM or SRAM by control bit
// [RQ24] after power-up or power-down wake, run from internal RC oscillator
package lprs_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int IRC_PERIOD_PS = 250000;
	localparam int IRC_WAKE_CYCLES = 4;
	localparam int IRC4_CLKS = (IRC_WAKE_CYCLES * IRC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PD_IRC_START_US = 60;
	localparam int PD_IRC_CLKS = (PD_IRC_START_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FLASH_WAKE_US = 100;
	localparam int FLASH_CLKS = (FLASH_WAKE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MAIN_WAKE_CYCLES = 4096;
	localparam int CLK_KHZ = 1000000000 / CLK_PERIOD_PS;
	localparam int RESET_WAIT_CLKS = 64;
	localparam int CNT_W = 20;
	// ****************************************************************
	// register map and fields
	// ****************************************************************
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_CLKCFG = 3'h1;
	localparam logic [2:0] REG_WAKE = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam int CTRL_SLEEP = 0;
	localparam int CTRL_PD = 1;
	localparam int CTRL_MAIN = 2;
	localparam int CTRL_MAP = 3;
	localparam int CFG_PLL_EN = 8;
	localparam int CFG_PLL_CONN = 9;
	localparam logic [31:0] RESET_PC = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] PROT_NONE = 2'h0;
	localparam logic [1:0] PROT_ONE = 2'h1;
	localparam logic [1:0] PROT_TWO = 2'h2;
	localparam logic [1:0] PROT_THREE = 2'h3;
	typedef enum logic [2:0] {ST_RESET, ST_RUN, ST_SLEEP, ST_PD, ST_IRC_START, ST_WAKE_DELAY}
		lprs_state_t;
	typedef struct packed {
		logic debug_en;
		logic isp_en;
		logic isp_sector0_lock;
		logic isp_erase_only;
		logic isp_entry_pin_en;
		logic iap_en;
	} lprs_prot_t;
endpackage

/* hdl/lprs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lprs_top import lprs_pkg::*; #(
	parameter int WAKE_N = 4,
	parameter int MAIN_OSC_KHZ = 12000,
	parameter int SLEEP_MAIN_CLKS = (MAIN_WAKE_CYCLES * (CLK_KHZ / 1000) * 1000 + MAIN_OSC_KHZ - 1)
		/ MAIN_OSC_KHZ,
	parameter int PD_IRC_WAIT = PD_IRC_CLKS,
	parameter int FLASH_WAIT = FLASH_CLKS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_reset_n,
	input wire logic wdt_reset,
	input wire logic por_reset,
	input wire logic brownout_stage1,
	input wire logic brownout_stage2,
	input wire logic osc_running,
	input wire logic flash_init_done,
	input wire logic [1:0] protect_level_in,
	input wire logic [WAKE_N-1:0] ext_wake_irq,
	input wire logic rtc_irq,
	output logic internal_reset_n,
	output logic [31:0] reset_fetch_addr,
	output logic cpu_run,
	output logic clk_gate_en,
	output logic main_osc_en,
	output logic irc_power_en,
	output logic irc_out_en,
	output logic rtc_osc_en,
	output logic pll_en,
	output logic pll_connect,
	output logic [3:0] cpu_clk_div,
	output logic [3:0] usb_clk_div,
	output logic flash_power_en,
	output logic flash_access_en,
	output logic pin_hold,
	output logic brownout_irq,
	output logic vector_map_sram,
	output lprs_prot_t prot
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		lprs_state_t state;
		logic [CNT_W-1:0] wcnt;
		logic [CNT_W-1:0] fcnt;
		logic flash_ok;
		logic clk_main;
		logic map_sram;
		logic pll_en;
		logic pll_conn;
		logic [3:0] cpu_div;
		logic [3:0] usb_div;
		logic [WAKE_N-1:0] wake_en;
		logic [1:0] prot_lvl;
		logic aw_ok;
		logic [2:0] aw_idx;
		logic aw_bad;
		logic w_ok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} lprs_regs_t;

	lprs_regs_t r;
	lprs_regs_t next_r;
	logic chip_rst;
	logic wake_evt;
	logic [31:0] status_word;

	// any of the four sources, stage-two brownout among them, resets the chip
	assign chip_rst = !ext_reset_n || wdt_reset || por_reset || brownout_stage2; // [RQ14] [RQ18]
	// only clockless sources: rtc and enabled external lines
	assign wake_evt = rtc_irq || |(ext_wake_irq & r.wake_en); // [RQ3] [RQ6] [RQ22]
	assign status_word = {27'h0, r.state == ST_RUN, r.prot_lvl, brownout_stage1, r.flash_ok}; // [RQ17]

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		next_r = r;
		// axi write channels taken in either order, answered once both are in
		if (s_axi_awvalid && s_axi_awready) begin
			next_r.aw_ok = 1'b1;
			next_r.aw_idx = s_axi_awaddr[4:2];
			next_r.aw_bad = s_axi_awaddr[31:4] != 28'h0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_r.w_ok = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end
		if (r.aw_ok && r.w_ok && !r.bvalid) begin
			next_r.aw_ok = 1'b0;
			next_r.w_ok = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = RESP_OKAY;
			if (r.aw_bad || r.aw_idx > REG_STATUS) begin
				next_r.bresp = RESP_SLVERR;
			end else if (r.aw_idx == REG_CTRL && r.wstrb[0]) begin
				next_r.clk_main = r.wdata[CTRL_MAIN];
				next_r.map_sram = r.wdata[CTRL_MAP]; // [RQ23]
				// mode entry only from run; command bits are not stored
				if (r.state == ST_RUN && (r.wdata[CTRL_SLEEP] || r.wdata[CTRL_PD])) begin
					next_r.state = r.wdata[CTRL_PD] ? ST_PD : ST_SLEEP;
					next_r.pll_en = 1'b0; // [RQ4]
					next_r.pll_conn = 1'b0; // [RQ4]
					next_r.cpu_div = 4'h0; // [RQ5]
					next_r.usb_div = 4'h0; // [RQ5]
					next_r.flash_ok = !r.wdata[CTRL_PD] && r.flash_ok; // [RQ7] [RQ11]
				end
			end else if (r.aw_idx == REG_CLKCFG) begin
				if (r.wstrb[0]) begin
					next_r.cpu_div = r.wdata[3:0];
					next_r.usb_div = r.wdata[7:4];
				end
				if (r.wstrb[1]) begin
					next_r.pll_en = r.wdata[CFG_PLL_EN];
					next_r.pll_conn = r.wdata[CFG_PLL_CONN];
				end
			end else if (r.aw_idx == REG_WAKE && r.wstrb[0]) begin
				next_r.wake_en = r.wdata[WAKE_N-1:0];
			end
		end
		// axi read: one outstanding, data captured at acceptance
		if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = RESP_OKAY;
			unique case (s_axi_araddr[4:2])
				REG_CTRL: next_r.rdata = {28'h0, r.map_sram, r.clk_main, 2'h0};
				REG_CLKCFG: next_r.rdata = {22'h0, r.pll_conn, r.pll_en, r.usb_div, r.cpu_div};
				REG_WAKE: next_r.rdata = {{(32 - WAKE_N){1'b0}}, r.wake_en};
				REG_STATUS: next_r.rdata = status_word;
				default: begin
					next_r.rdata = 32'h0;
					next_r.rresp = RESP_SLVERR;
				end
			endcase
			if (s_axi_araddr[31:5] != 27'h0 || s_axi_araddr[4:2] > REG_STATUS) begin
				next_r.rdata = 32'h0;
				next_r.rresp = RESP_SLVERR;
			end
		end
		// flash wake-up counter runs beside the execution counter
		// a power-down entry in this cycle wins over the counter finishing
		if (!r.flash_ok && r.state != ST_PD && r.state != ST_IRC_START && next_r.state != ST_PD) begin
			if (r.fcnt == '0) begin
				next_r.flash_ok = 1'b1; // [RQ13]
			end else begin
				next_r.fcnt = r.fcnt - 1'b1; // [RQ13]
			end
		end
		// power sequencer
		unique case (r.state)
			ST_RESET: begin
				if (r.wcnt != '0) begin
					next_r.wcnt = r.wcnt - 1'b1;
				end else if (ext_reset_n && osc_running && flash_init_done) begin // [RQ15]
					next_r.state = ST_RUN;
					next_r.prot_lvl = protect_level_in;
				end
			end
			ST_RUN: begin
			end
			ST_SLEEP: begin
				if (wake_evt) begin
					next_r.state = ST_WAKE_DELAY;
					// prior clock decides the hold-off
					next_r.wcnt = r.clk_main ? CNT_W'(SLEEP_MAIN_CLKS - 1) // [RQ9]
						: CNT_W'(IRC4_CLKS - 1); // [RQ8]
				end
			end
			ST_PD: begin
				if (wake_evt) begin
					next_r.state = ST_IRC_START;
					next_r.clk_main = 1'b0; // [RQ24]
					next_r.wcnt = CNT_W'(PD_IRC_WAIT - 1); // [RQ12]
				end
			end
			ST_IRC_START: begin
				if (r.wcnt != '0) begin
					next_r.wcnt = r.wcnt - 1'b1;
				end else begin
					next_r.state = ST_WAKE_DELAY;
					next_r.wcnt = CNT_W'(IRC4_CLKS - 1); // [RQ12]
					next_r.fcnt = CNT_W'(FLASH_WAIT - 1); // [RQ13]
				end
			end
			ST_WAKE_DELAY: begin
				if (r.wcnt != '0) begin
					next_r.wcnt = r.wcnt - 1'b1;
				end else begin
					next_r.state = ST_RUN;
				end
			end
		endcase
		// chip reset: sequencer state back to defaults, bus handshake untouched
		if (chip_rst) begin
			next_r.state = ST_RESET; // [RQ15]
			next_r.wcnt = CNT_W'(RESET_WAIT_CLKS - 1);
			next_r.flash_ok = 1'b1;
			next_r.clk_main = 1'b0; // [RQ24]
			next_r.map_sram = 1'b0; // [RQ16]
			next_r.pll_en = 1'b0;
			next_r.pll_conn = 1'b0;
			next_r.cpu_div = 4'h0;
			next_r.usb_div = 4'h0;
			next_r.wake_en = '0;
		end
	end

	// single register for all state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.state <= ST_RESET;
			r.wcnt <= CNT_W'(RESET_WAIT_CLKS - 1);
			r.flash_ok <= 1'b1;
			r.prot_lvl <= PROT_THREE;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// bus handshakes: one pending word per channel
	assign s_axi_awready = !r.aw_ok;
	assign s_axi_wready = !r.w_ok;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	// clock and power controls follow the sequencer state
	assign internal_reset_n = r.state != ST_RESET; // [RQ15]
	assign reset_fetch_addr = RESET_PC; // [RQ16]
	assign cpu_run = r.state == ST_RUN;
	assign clk_gate_en = r.state == ST_RUN; // [RQ1]
	assign main_osc_en = r.clk_main && (r.state == ST_RUN || r.state == ST_WAKE_DELAY); // [RQ1]
	assign irc_power_en = r.state != ST_PD; // [RQ2] [RQ11]
	assign irc_out_en = r.state != ST_SLEEP && r.state != ST_PD; // [RQ2]
	assign rtc_osc_en = 1'b1; // [RQ3]
	assign pll_en = r.pll_en;
	assign pll_connect = r.pll_conn;
	assign cpu_clk_div = r.cpu_div;
	assign usb_clk_div = r.usb_div;
	assign flash_power_en = r.state != ST_PD && r.state != ST_IRC_START; // [RQ7] [RQ11]
	assign flash_access_en = r.flash_ok && r.state == ST_RUN; // [RQ13]
	assign pin_hold = r.state == ST_SLEEP || r.state == ST_PD; // [RQ1]
	assign brownout_irq = brownout_stage1; // [RQ17]
	assign vector_map_sram = r.map_sram; // [RQ23]
	// protection level latched at reset release; in-application path never blocked
	always_comb begin
		prot.debug_en = r.prot_lvl == PROT_NONE; // [RQ19] [RQ20] [RQ21]
		prot.isp_en = r.prot_lvl != PROT_THREE; // [RQ21]
		prot.isp_sector0_lock = r.prot_lvl == PROT_ONE; // [RQ19]
		prot.isp_erase_only = r.prot_lvl == PROT_TWO; // [RQ20]
		prot.isp_entry_pin_en = r.prot_lvl != PROT_THREE; // [RQ21]
		prot.iap_en = 1'b1; // [RQ19]
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	reset_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ15]
		chip_rst |=> !internal_reset_n [*8]) else $error("internal reset released too early");
	sleep_clocks_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1]
		r.state == ST_SLEEP |-> !clk_gate_en && !main_osc_en && pin_hold && irc_power_en)
		else $error("clocks running in sleep");
	pll_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ4]
		$rose(pin_hold) |-> !pll_en && !pll_connect && cpu_clk_div == 4'h0)
		else $error("pll or divider not cleared on entry");
	pd_flash_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
		r.state == ST_PD |-> !flash_power_en && !irc_power_en && !r.flash_ok)
		else $error("flash or oscillator powered in power-down");
	irc_wake_a: assert property (@(posedge aclk) disable iff (!aresetn || chip_rst) // [RQ8]
		r.state == ST_SLEEP && wake_evt && !r.clk_main |-> ##250 !cpu_run ##1 cpu_run)
		else $error("sleep wake delay wrong");
	pd_wake_a: assert property (@(posedge aclk) disable iff (!aresetn || chip_rst) // [RQ12]
		r.state == ST_IRC_START && r.wcnt == '0 |-> ##250 !cpu_run ##1 cpu_run && !flash_access_en)
		else $error("power-down resume delay wrong");
	wake_only_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ6]
		r.state == ST_SLEEP && !wake_evt && !chip_rst |=> r.state == ST_SLEEP)
		else $error("sleep left without wake source");
	prot_three_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ21]
		r.prot_lvl == PROT_THREE |-> !prot.isp_en && !prot.isp_entry_pin_en && !prot.debug_en)
		else $error("level three access open");
	bod_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ17]
		brownout_stage1 |-> brownout_irq && status_word[1]) else $error("brownout not flagged");
endmodule // lprs_top
`default_nettype wire

/* dv/lprs_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// oscillator and flash controller stand-in
// ****************************************************************
module lprs_far_end #(
	parameter int OSC_DLY = 5,
	parameter int FLASH_DLY = 8
) (
	input wire logic aclk,
	input wire logic flash_power_en,
	output logic osc_running,
	output logic flash_init_done
);
	int oc = 0;
	int fc = 0;
	// flash init is lost when power drops, so a slow restart is seen
	always @(posedge aclk) begin
		if (oc < OSC_DLY) oc <= oc + 1;
		if (!flash_power_en) fc <= 0;
		else if (fc < FLASH_DLY) fc <= fc + 1;
	end
	assign osc_running = (oc == OSC_DLY);
	assign flash_init_done = (fc == FLASH_DLY);
endmodule // lprs_far_end
`default_nettype wire

/* dv/lprs_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module lprs_top_tb;
	import lprs_pkg::*;
	localparam int SMC = 20;
	localparam int PDW = 10;
	localparam int FW = 400;
	logic aclk = 0, aresetn = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, ext_wake_irq = 4'h0, cpu_clk_div, usb_clk_div;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, protect_level_in = 2'h0;
	logic ext_reset_n = 1, wdt_reset = 0, por_reset = 0, brownout_stage1 = 0, brownout_stage2 = 0;
	logic rtc_irq = 0, osc_running, flash_init_done, internal_reset_n, cpu_run, clk_gate_en;
	logic main_osc_en, irc_power_en, irc_out_en, rtc_osc_en, pll_en, pll_connect;
	logic flash_power_en, flash_access_en, pin_hold, brownout_irq, vector_map_sram;
	logic [31:0] reset_fetch_addr;
	lprs_prot_t prot;
	int n_mismatch = 0;
	int checked = 0;
	always #2 aclk = ~aclk;
	lprs_top #(.SLEEP_MAIN_CLKS(SMC), .PD_IRC_WAIT(PDW), .FLASH_WAIT(FW)) i_lprs_top (.aclk,
		.aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ext_reset_n, .wdt_reset, .por_reset, .brownout_stage1, .brownout_stage2, .osc_running,
		.flash_init_done, .protect_level_in, .ext_wake_irq, .rtc_irq, .internal_reset_n,
		.reset_fetch_addr, .cpu_run, .clk_gate_en, .main_osc_en, .irc_power_en, .irc_out_en,
		.rtc_osc_en, .pll_en, .pll_connect, .cpu_clk_div, .usb_clk_div, .flash_power_en,
		.flash_access_en, .pin_hold, .brownout_irq, .vector_map_sram, .prot);
	lprs_far_end i_lprs_far_end (.aclk(aclk), .flash_power_en(flash_power_en),
		.osc_running(osc_running), .flash_init_done(flash_init_done));
	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic tmo();
		n_mismatch++;
		$display("[ERR] %0t wait limit got %h exp %h", $time, 0, 1);
		wrap_up();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// measured counts carry a small margin for the sampling skew of the loop
	task automatic rng(input int n, input int nom);
		checked++;
		if (n < nom - 2 || n > nom + 4) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, n, nom);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic cnt(input bit fl, output int n);
		n = 0;
		while ((fl ? flash_access_en : cpu_run) !== 1'b1) begin
			@(posedge aclk);
			n++;
			if (n > 3000) tmo();
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bit pa, pw;
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		pa = 1;
		pw = 1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (pa && s_axi_awready) begin
				pa = 0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready) begin
				pw = 0;
				s_axi_wvalid <= 1'b0;
			end
			if (!pa && !pw && s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (i >= 200) tmo();
		chk(s_axi_bresp, RESP_OKAY);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		bit pa;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		pa = 1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (pa && s_axi_arready) begin
				pa = 0;
				s_axi_arvalid <= 1'b0;
			end
			else if (!pa && s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (i >= 200) tmo();
		@(posedge aclk);
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_sleep();
		int n;
		wr(32'h4, 32'h0000_03FF);
		wr(32'h0, 32'h1);
		tk(2);
		chk({clk_gate_en, main_osc_en, pin_hold}, 3'h1);
		chk({irc_out_en, irc_power_en, rtc_osc_en}, 3'h3);
		chk({pll_en, pll_connect, cpu_clk_div, usb_clk_div}, 10'h000);
		chk(flash_power_en, 1'b1);
		ext_wake_irq <= 4'hF;
		tk(300);
		chk(cpu_run, 1'b0);
		ext_wake_irq <= 4'h0;
		rtc_irq <= 1'b1;
		cnt(0, n);
		rtc_irq <= 1'b0;
		rng(n, 251);
		chk(flash_access_en, 1'b1);
		$display("sleep from rc clock done");
	endtask
	task automatic t_main();
		int n;
		wr(32'h4, 32'h0000_0111);
		wr(32'h0, 32'h5);
		tk(2);
		rtc_irq <= 1'b1;
		cnt(0, n);
		rtc_irq <= 1'b0;
		rng(n, SMC + 1);
		$display("sleep from main oscillator done");
	endtask
	task automatic t_pd();
		int n;
		wr(32'h8, 32'h1);
		wr(32'h0, 32'h2);
		tk(2);
		chk({irc_power_en, flash_power_en, pin_hold, pll_en}, 4'h2);
		ext_wake_irq <= 4'h1;
		cnt(0, n);
		ext_wake_irq <= 4'h0;
		rng(n, PDW + 251);
		chk({flash_access_en, irc_out_en}, 2'h1);
		cnt(1, n);
		rng(n, FW - 250);
		$display("power-down wake done");
	endtask
	task automatic t_map();
		logic [31:0] d;
		logic [1:0] r;
		wr(32'h0, 32'h8);
		chk(vector_map_sram, 1'b1);
		rd(32'h0, d, r);
		chk(d[3], 1'b1);
		rd(32'h40, d, r);
		chk(r, RESP_SLVERR);
		$display("vector map done");
	endtask
	task automatic t_bod();
		int n;
		logic [31:0] d;
		logic [1:0] r;
		brownout_stage1 <= 1'b1;
		tk(2);
		chk(brownout_irq, 1'b1);
		rd(32'hC, d, r);
		chk(d[1], 1'b1);
		brownout_stage1 <= 1'b0;
		brownout_stage2 <= 1'b1;
		tk(3);
		chk(internal_reset_n, 1'b0);
		brownout_stage2 <= 1'b0;
		cnt(0, n);
		$display("brownout done");
	endtask
	task automatic t_rst();
		int n;
		for (int s = 0; s < 3; s++) begin
			ext_reset_n <= (s != 0);
			wdt_reset <= (s == 1);
			por_reset <= (s == 2);
			tk(100);
			chk(internal_reset_n, 1'b0);
			ext_reset_n <= 1'b1;
			wdt_reset <= 1'b0;
			por_reset <= 1'b0;
			cnt(0, n);
			chk(n >= RESET_WAIT_CLKS, 1'b1);
			chk(reset_fetch_addr, RESET_PC);
			chk(internal_reset_n, 1'b1);
		end
		$display("reset sources done");
	endtask
	task automatic t_prot();
		int n;
		logic [5:0] e[4] = '{6'h33, 6'h1B, 6'h17, 6'h01};
		for (int l = 0; l < 4; l++) begin
			protect_level_in <= 2'(l);
			wdt_reset <= 1'b1;
			tk(2);
			wdt_reset <= 1'b0;
			cnt(0, n);
			chk(prot, e[l]);
		end
		$display("protection levels done");
	endtask
	initial begin
		int n;
		tk(12);
		aresetn <= 1'b1;
		cnt(0, n);
		chk({irc_out_en, rtc_osc_en}, 2'h3);
		chk(reset_fetch_addr, RESET_PC);
		t_sleep();
		t_main();
		t_pd();
		t_map();
		t_bod();
		t_rst();
		t_prot();
		wrap_up();
	end
endmodule // lprs_top_tb
`default_nettype wire
